// ### src/cpu_register_file_and_flags.sv
// CPU register file, condition flags, operand selector decode and Avalon-MM slave.
// Assumes a synchronous Avalon master on clk; datapath results arrive on clk.
//
// Function
// - Vector base register supplies upper byte of vectored interrupt table address.
// - Reset clears the vector base register to zero.
// - Low seven counter bits increment on every opcode fetch cycle.
// - Reset clears the instruction counter to zero.
// - Reset clears the 16-bit stack pointer to zero.
// - Reset clears the program counter so first fetch is at zero.
// - Program counter advances after every fetch to point at next instruction.
// - Sign flag bit 7 takes result top bit.
// - Zero flag bit 6 set for all-zero result, else cleared.
// - Half-carry bit 4 records carry or borrow from low nibble (8-bit) or out of bit 11 (16-bit).
// - Logic operations set parity flag for even count of ones.
// - Arithmetic sets overflow flag when signed range exceeded, 8 or 16 bits.
// - Subtract flag set for subtract, decrement, compare; cleared for add.
// - Carry bit 0 from top-bit carry or borrow; shifts also change it.
// - Byte select 000-101 is B,C,D,E,H,L; 111 accumulator; 110 none.
// - Pair select 00 BC, 01 DE, 10 HL/IX/IY, 11 SP or AF.
// - Register indirect takes address from BC, DE or HL.
// - Indexed address is index register plus instruction displacement.
// - Eight addressing modes supported by operand logic.
// - Implied mode picks registers from opcode without select field.
// - Alternate set not directly accessible; exchange swaps with primary.
// - Displacement is 8-bit signed, sign-extended before adding.
`include "cpu_regs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic opcode_fetch_cycle,
    input wire logic [7:0] res_value,
    input wire logic [15:0] res_wide,
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] opnd_b,
    input wire logic [15:0] opnd_wa,
    input wire logic [15:0] opnd_wb,
    input wire logic carry_in,
    input wire cpu_regs_pkg::op_class_t op_class,
    input wire logic res_wide_sel,
    input wire logic flags_update,
    input wire logic shift_carry,
    input wire logic exchange,
    input wire logic [2:0] byte_sel,
    input wire logic [1:0] pair_sel,
    input wire cpu_regs_pkg::pair_field_t pair_field,
    input wire cpu_regs_pkg::addr_mode_t addr_mode,
    input wire logic [1:0] implied_sel,
    input wire logic [7:0] displacement,
    input wire logic [15:0] imm_word,
    output logic [7:0] vector_base,
    output logic [7:0] condition_flags,
    output logic [15:0] operand_addr,
    output logic [7:0] byte_operand,
    output logic byte_sel_valid,
    output logic [15:0] pair_operand,
    output logic [15:0] program_counter,
    output logic [15:0] stack_pointer
);
    import cpu_regs_pkg::*;

    state_t s_q;
    state_t s_d;

    function automatic logic [7:0] byte_pick(input state_t s, input logic [2:0] code);
        unique case (code)
            3'h0: byte_pick = s.bc[15:8];
            3'h1: byte_pick = s.bc[7:0];
            3'h2: byte_pick = s.de[15:8];
            3'h3: byte_pick = s.de[7:0];
            3'h4: byte_pick = s.hl[15:8];
            3'h5: byte_pick = s.hl[7:0];
            3'h6: byte_pick = 8'h00;
            3'h7: byte_pick = s.acc;
        endcase
    endfunction : byte_pick

    function automatic logic [15:0] pair_pick(input state_t s, input logic [1:0] code, input pair_field_t ft);
        unique case (code)
            2'h0: pair_pick = s.bc;
            2'h1: pair_pick = s.de;
            2'h2: pair_pick = (ft == FT_XX) ? s.ixr : ((ft == FT_YY) ? s.iyr : s.hl);
            2'h3: pair_pick = (ft == FT_ZZ) ? {s.acc, s.flags} : s.sp;
        endcase
    endfunction : pair_pick

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        lane_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                lane_merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : lane_merge

    logic [7:0] flags_next;
    logic [15:0] ea_next;
    logic [15:0] res_sel;
    logic [31:0] wmerged;
    logic [31:0] rd_mux;

    // Flag derivation from current datapath result
    always_comb begin
        logic [4:0] nib;
        logic [8:0] b9;
        logic [16:0] w17;
        logic [12:0] w13;
        logic ovf;
        logic cy;
        logic hc;
        nib = 5'h00;
        b9 = 9'h000;
        w17 = 17'h00000;
        w13 = 13'h0000;
        ovf = 1'b0;
        cy = 1'b0;
        hc = 1'b0;
        flags_next = s_q.flags;
        res_sel = res_wide_sel ? res_wide : {8'h00, res_value};
        if (op_class == OP_SUB) begin
            nib = {1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} - {4'h0, carry_in};
            b9 = {1'b0, opnd_a} - {1'b0, opnd_b} - {8'h00, carry_in};
            w17 = {1'b0, opnd_wa} - {1'b0, opnd_wb} - {16'h0000, carry_in};
            w13 = {1'b0, opnd_wa[11:0]} - {1'b0, opnd_wb[11:0]} - {12'h000, carry_in};
        end else begin
            nib = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, carry_in};
            b9 = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, carry_in};
            w17 = {1'b0, opnd_wa} + {1'b0, opnd_wb} + {16'h0000, carry_in};
            w13 = {1'b0, opnd_wa[11:0]} + {1'b0, opnd_wb[11:0]} + {12'h000, carry_in};
        end
        if (res_wide_sel) begin
            cy = w17[16];
            hc = w13[12];
            ovf = (op_class == OP_SUB) ? ((opnd_wa[15] != opnd_wb[15]) && (w17[15] != opnd_wa[15]))
                                       : ((opnd_wa[15] == opnd_wb[15]) && (w17[15] != opnd_wa[15]));
        end else begin
            cy = b9[8];
            hc = nib[4];
            ovf = (op_class == OP_SUB) ? ((opnd_a[7] != opnd_b[7]) && (b9[7] != opnd_a[7]))
                                       : ((opnd_a[7] == opnd_b[7]) && (b9[7] != opnd_a[7]));
        end
        if (flags_update && op_class != OP_NONE) begin
            flags_next[`FLG_SIGN] = res_wide_sel ? res_wide[15] : res_value[7];
            flags_next[`FLG_ZERO] = (res_sel == 16'h0000);
            unique case (op_class)
                OP_ADD, OP_SUB: begin
                    flags_next[`FLG_HALF] = hc;
                    flags_next[`FLG_PV] = ovf;
                    flags_next[`FLG_SUB] = (op_class == OP_SUB);
                    flags_next[`FLG_CARRY] = cy;
                end
                OP_LOGIC: begin
                    flags_next[`FLG_PV] = ~(^res_value);
                    flags_next[`FLG_SUB] = 1'b0;
                end
                OP_SHIFT: begin
                    flags_next[`FLG_PV] = ~(^res_value);
                    flags_next[`FLG_SUB] = 1'b0;
                    flags_next[`FLG_CARRY] = shift_carry;
                end
                default: begin
                    flags_next[`FLG_SUB] = s_q.flags[`FLG_SUB];
                end
            endcase
        end
    end

    // Operand address formation by addressing mode
    always_comb begin
        ea_next = 16'h0000;
        unique case (addr_mode)
            AM_IMPLIED: begin
                unique case (implied_sel)
                    2'h0: ea_next = {8'h00, s_q.acc};
                    2'h1: ea_next = s_q.ixr;
                    2'h2: ea_next = s_q.sp;
                    2'h3: ea_next = s_q.hl;
                endcase
            end
            AM_REG_DIRECT: ea_next = pair_pick(s_q, pair_sel, pair_field);
            AM_REG_INDIRECT: begin
                unique case (pair_sel)
                    2'h0: ea_next = s_q.bc;
                    2'h1: ea_next = s_q.de;
                    default: ea_next = s_q.hl;
                endcase
            end
            AM_INDEXED: ea_next = (pair_field == FT_YY ? s_q.iyr : s_q.ixr)
                                  + {{8{displacement[7]}}, displacement};
            AM_EXTENDED: ea_next = imm_word;
            AM_IMMEDIATE: ea_next = s_q.pc;
            AM_RELATIVE: ea_next = s_q.pc + {{8{displacement[7]}}, displacement};
            AM_IO: ea_next = {8'h00, s_q.bc[7:0]};
        endcase
    end

    always_comb begin
        unique case (avs_address)
            `ADDR_FLAGS: rd_mux = {24'h0, s_q.flags};
            `ADDR_ACC: rd_mux = {24'h0, s_q.acc};
            `ADDR_BC: rd_mux = {16'h0, s_q.bc};
            `ADDR_DE: rd_mux = {16'h0, s_q.de};
            `ADDR_HL: rd_mux = {16'h0, s_q.hl};
            `ADDR_IXR: rd_mux = {16'h0, s_q.ixr};
            `ADDR_IYR: rd_mux = {16'h0, s_q.iyr};
            `ADDR_SPR: rd_mux = {16'h0, s_q.sp};
            `ADDR_PCR: rd_mux = {16'h0, s_q.pc};
            `ADDR_VEC: rd_mux = {24'h0, s_q.vec_base};
            `ADDR_CNT: rd_mux = {24'h0, s_q.instr_cnt};
            `ADDR_CTRL: rd_mux = {24'h0, s_q.ctrl};
            `ADDR_EA: rd_mux = {16'h0, s_q.ea};
            `ADDR_SEL: rd_mux = {16'h0, s_q.sel, byte_pick(s_q, byte_sel)};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign wmerged = lane_merge(rd_mux, avs_writedata, avs_byteenable);

    always_comb begin
        logic fetch;
        logic swap;
        fetch = opcode_fetch_cycle | s_q.ctrl[`CTRL_FETCH];
        swap = exchange | s_q.ctrl[`CTRL_SWAP];
        s_d = s_q;
        s_d.ctrl[`CTRL_FETCH] = 1'b0;
        s_d.ctrl[`CTRL_SWAP] = 1'b0;
        s_d.flags = flags_next;
        s_d.ea = ea_next;
        s_d.sel = {5'h00, byte_sel};
        if (fetch) begin
            s_d.instr_cnt = {s_q.instr_cnt[7], 7'(s_q.instr_cnt[6:0] + 7'h01)};
            s_d.pc = s_q.pc + 16'h0001;
        end
        if (swap) begin
            s_d.acc = s_q.acc_alt;
            s_d.flags = s_q.flags_alt;
            s_d.bc = s_q.bc_alt;
            s_d.de = s_q.de_alt;
            s_d.hl = s_q.hl_alt;
            s_d.acc_alt = s_q.acc;
            s_d.flags_alt = flags_next;
            s_d.bc_alt = s_q.bc;
            s_d.de_alt = s_q.de;
            s_d.hl_alt = s_q.hl;
        end
        s_d.rdata = s_q.rdata;
        s_d.bus = BUS_IDLE;
        unique case (s_q.bus)
            BUS_IDLE: begin
                if (avs_read) begin
                    s_d.rdata = rd_mux;
                    s_d.bus = BUS_DONE;
                end else if (avs_write) begin
                    s_d.bus = BUS_DONE;
                end
            end
            BUS_DONE: begin
                // Write lands at the edge where waitrequest is seen low
                s_d.bus = BUS_IDLE;
                if (avs_write) begin
                    unique case (avs_address)
                        `ADDR_FLAGS: s_d.flags = wmerged[7:0];
                        `ADDR_ACC: s_d.acc = wmerged[7:0];
                        `ADDR_BC: s_d.bc = wmerged[15:0];
                        `ADDR_DE: s_d.de = wmerged[15:0];
                        `ADDR_HL: s_d.hl = wmerged[15:0];
                        `ADDR_IXR: s_d.ixr = wmerged[15:0];
                        `ADDR_IYR: s_d.iyr = wmerged[15:0];
                        `ADDR_SPR: s_d.sp = wmerged[15:0];
                        `ADDR_PCR: s_d.pc = wmerged[15:0];
                        `ADDR_VEC: s_d.vec_base = wmerged[7:0];
                        `ADDR_CNT: s_d.instr_cnt = wmerged[7:0];
                        `ADDR_CTRL: s_d.ctrl = wmerged[7:0];
                        default: s_d.rdata = s_q.rdata;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.bus <= BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) && (s_q.bus != BUS_DONE);
    assign avs_readdata = s_q.rdata;
    assign vector_base = s_q.vec_base;
    assign condition_flags = s_q.flags;
    assign operand_addr = s_q.ea;
    assign byte_operand = byte_pick(s_q, byte_sel);
    assign byte_sel_valid = (byte_sel != 3'h6);
    assign pair_operand = pair_pick(s_q, pair_sel, pair_field);
    assign program_counter = s_q.pc;
    assign stack_pointer = s_q.sp;

    property p_cnt_step;
        @(posedge clk) disable iff (!rst_b)
        (opcode_fetch_cycle && !(avs_write && !avs_waitrequest))
            |=> s_q.instr_cnt[6:0] == 7'($past(s_q.instr_cnt[6:0]) + 7'h01)
                && s_q.instr_cnt[7] == $past(s_q.instr_cnt[7]);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong");

    property p_pc_step;
        @(posedge clk) disable iff (!rst_b)
        (opcode_fetch_cycle && !avs_write) |=> program_counter == $past(program_counter) + 16'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

    property p_zero;
        @(posedge clk) disable iff (!rst_b)
        (flags_update && op_class != OP_NONE && !avs_write && !exchange && !s_q.ctrl[`CTRL_SWAP])
            |=> condition_flags[`FLG_ZERO] == ($past(res_sel) == 16'h0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sign;
        @(posedge clk) disable iff (!rst_b)
        (flags_update && op_class != OP_NONE && !res_wide_sel && !avs_write && !exchange && !s_q.ctrl[`CTRL_SWAP])
            |=> condition_flags[`FLG_SIGN] == $past(res_value[7]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");

    property p_nflag;
        @(posedge clk) disable iff (!rst_b)
        (flags_update && op_class == OP_SUB && !avs_write && !exchange && !s_q.ctrl[`CTRL_SWAP])
            |=> condition_flags[`FLG_SUB];
    endproperty
    a_nflag: assert property (p_nflag) else $error("subtract flag not set");

    property p_parity;
        @(posedge clk) disable iff (!rst_b)
        (flags_update && op_class == OP_LOGIC && !avs_write && !exchange && !s_q.ctrl[`CTRL_SWAP])
            |=> condition_flags[`FLG_PV] == ~(^$past(res_value));
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");

    property p_sel110;
        @(posedge clk) disable iff (!rst_b)
        byte_sel == 3'h6 |-> !byte_sel_valid && byte_operand == 8'h00;
    endproperty
    a_sel110: assert property (p_sel110) else $error("code 110 selected a register");

    property p_idx;
        @(posedge clk) disable iff (!rst_b)
        (addr_mode == AM_INDEXED && pair_field == FT_XX)
            |=> operand_addr == $past(s_q.ixr) + {{8{$past(displacement[7])}}, $past(displacement)};
    endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");

    property p_wait;
        @(posedge clk) disable iff (!rst_b)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
endmodule : cpu_register_file_and_flags
`default_nettype wire

// ### include/cpu_regs_regs.svh
// Register offsets, field positions, reset values and counts for the CPU register file.
// Assumes inclusion by bare name with include guard.
`ifndef CPU_REGS_REGS_SVH
`define CPU_REGS_REGS_SVH
`define ADDR_FLAGS 8'h00
`define ADDR_ACC 8'h04
`define ADDR_BC 8'h08
`define ADDR_DE 8'h0C
`define ADDR_HL 8'h10
`define ADDR_IXR 8'h14
`define ADDR_IYR 8'h18
`define ADDR_SPR 8'h1C
`define ADDR_PCR 8'h20
`define ADDR_VEC 8'h24
`define ADDR_CNT 8'h28
`define ADDR_CTRL 8'h2C
`define ADDR_EA 8'h30
`define ADDR_SEL 8'h34
`define FLG_SIGN 7
`define FLG_ZERO 6
`define FLG_HALF 4
`define FLG_PV 2
`define FLG_SUB 1
`define FLG_CARRY 0
`define FLG_DEF_MASK 8'hD7
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CNT_LOW_MASK 8'h7F
`define CTRL_FETCH 0
`define CTRL_SWAP 1
`define CTRL_EXEC 2
`define CTRL_WIDE 3
`endif

// ### include/cpu_regs_pkg.sv
// Types for the CPU register file: operation classes, addressing modes and state.
// Assumes the _regs.svh header supplies all numbers.
package cpu_regs_pkg;
    typedef enum logic [2:0] {
        OP_ADD = 3'h0, OP_SUB = 3'h1, OP_LOGIC = 3'h2, OP_SHIFT = 3'h3, OP_NONE = 3'h4
    } op_class_t;
    typedef enum logic [2:0] {
        AM_IMPLIED = 3'h0, AM_REG_DIRECT = 3'h1, AM_REG_INDIRECT = 3'h2, AM_INDEXED = 3'h3,
        AM_EXTENDED = 3'h4, AM_IMMEDIATE = 3'h5, AM_RELATIVE = 3'h6, AM_IO = 3'h7
    } addr_mode_t;
    typedef enum logic [1:0] {
        FT_WW = 2'h0, FT_XX = 2'h1, FT_YY = 2'h2, FT_ZZ = 2'h3
    } pair_field_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01, BUS_DONE = 2'b10
    } bus_state_t;
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [15:0] bc;
        logic [15:0] de;
        logic [15:0] hl;
        logic [7:0] acc_alt;
        logic [7:0] flags_alt;
        logic [15:0] bc_alt;
        logic [15:0] de_alt;
        logic [15:0] hl_alt;
        logic [7:0] vec_base;
        logic [7:0] instr_cnt;
        logic [15:0] ixr;
        logic [15:0] iyr;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] ctrl;
        logic [7:0] sel;
        logic [15:0] ea;
        logic [31:0] rdata;
        bus_state_t bus;
    } state_t;
endpackage : cpu_regs_pkg

// ### verif/alu_partner.sv
// Behavioural ALU datapath that feeds byte results to the register file.
// Assumes the bench holds operands stable while flags are taken.
`timescale 1ns/1ps
`default_nettype none
module alu_partner (
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] opnd_b,
    input wire logic carry_in,
    input wire cpu_regs_pkg::op_class_t op_class,
    output logic [7:0] res_value
);
    import cpu_regs_pkg::*;
    always_comb begin
        case (op_class)
            OP_ADD: res_value = opnd_a + opnd_b + {7'h00, carry_in};
            OP_SUB: res_value = opnd_a - opnd_b - {7'h00, carry_in};
            OP_LOGIC: res_value = opnd_a & opnd_b;
            OP_SHIFT: res_value = {opnd_a[6:0], carry_in};
            default: res_value = opnd_a;
        endcase
    end
endmodule : alu_partner
`default_nettype wire

// ### verif/cpu_register_file_and_flags_test.sv
// Self-checking bench: bus access, fetch counting, exchange, flags, selects, address forming.
// Assumes alu_partner supplies the byte result from the operands driven here.
`include "cpu_regs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags_test;
    import cpu_regs_pkg::*;
    logic clk, avs_waitrequest, bvalid;
    logic rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, fetch = 1'b0, cin = 1'b0, fupd = 1'b0, xchg = 1'b0;
    logic [7:0] avs_address = 8'h00, opa = 8'h00, opb = 8'h00, disp = 8'h00;
    logic [7:0] res, vbase, flags, bop, m_flags;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [15:0] wa = 16'h0000, wb = 16'h0000, rw = 16'h0000, imm = 16'h0000, lf = 16'h9799;
    logic [15:0] oaddr, pop, pc, sp;
    logic [2:0] bsel = 3'h0;
    logic [1:0] psel = 2'h0, isel = 2'h0;
    logic [7:0] bt [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00, 8'h5A};
    op_class_t op = OP_NONE;
    pair_field_t pf = FT_WW;
    addr_mode_t am = AM_IMPLIED;
    int n_fail = 0, compares = 0;

    cpu_register_file_and_flags u_cpu_register_file_and_flags (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .opcode_fetch_cycle(fetch), .res_value(res), .res_wide(rw),
        .opnd_a(opa), .opnd_b(opb), .opnd_wa(wa), .opnd_wb(wb), .carry_in(cin), .op_class(op),
        .res_wide_sel(1'b0), .flags_update(fupd), .shift_carry(cin), .exchange(xchg), .byte_sel(bsel),
        .pair_sel(psel), .pair_field(pf), .addr_mode(am), .implied_sel(isel), .displacement(disp),
        .imm_word(imm), .vector_base(vbase), .condition_flags(flags), .operand_addr(oaddr),
        .byte_operand(bop), .byte_sel_valid(bvalid), .pair_operand(pop), .program_counter(pc),
        .stack_pointer(sp)
    );
    alu_partner u_alu_partner (.opnd_a(opa), .opnd_b(opb), .carry_in(cin), .op_class(op), .res_value(res));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    function automatic logic [15:0] pe(input int f, input int s);
        case (s)
            0: return 16'h1122;
            1: return 16'h3344;
            2: return f == 1 ? 16'h7788 : f == 2 ? 16'h99AA : 16'h5566;
            default: return f == 3 ? 16'h5A28 : 16'hBBCC;
        endcase
    endfunction : pe

    task automatic stop_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic wt;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        do begin
            @(negedge clk);
            wt = avs_waitrequest;
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (n >= 50) n_fail++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rdc

    task automatic xp();
        @(posedge clk);
        xchg <= 1'b1;
        @(posedge clk);
        xchg <= 1'b0;
    endtask : xp

    task automatic alu(input op_class_t o, input logic [7:0] a, input logic [7:0] b, input logic c);
        int r;
        logic [7:0] e, m;
        e = m_flags;
        m = 8'hFF;
        @(posedge clk);
        op <= o;
        opa <= a;
        opb <= b;
        cin <= c;
        fupd <= 1'b1;
        @(posedge clk);
        fupd <= 1'b0;
        #1;
        case (o)
            OP_ADD: begin
                r = a + b + c;
                e[4] = (a[3:0] + b[3:0] + c) > 15;
                e[2] = (a[7] == b[7]) && (r[7] != a[7]);
                e[1] = 1'b0;
                e[0] = r[8];
            end
            OP_SUB: begin
                r = a - b - c;
                e[4] = int'(a[3:0]) < int'(b[3:0]) + c;
                e[2] = (a[7] != b[7]) && (r[7] != a[7]);
                e[1] = 1'b1;
                e[0] = r < 0;
            end
            OP_LOGIC: begin
                r = a & b;
                e[2] = ~^r[7:0];
                m = 8'hEC;
            end
            default: begin
                r = 0;
                e[0] = c;
                m = 8'h29;
            end
        endcase
        if (o != OP_SHIFT) begin
            e[7] = r[7];
            e[6] = r[7:0] == 0;
        end
        m_flags = e;
        chk(flags & m, e & m);
    endtask : alu

    task automatic amc(input addr_mode_t mo, input pair_field_t f, input logic [1:0] ps, input logic [1:0] is,
            input logic [7:0] d, input logic [15:0] e);
        @(posedge clk);
        am <= mo;
        pf <= f;
        psel <= ps;
        isel <= is;
        disp <= d;
        @(posedge clk);
        #1;
        chk(oaddr, e);
    endtask : amc

    initial begin
        #50000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(`ADDR_SPR, 32'h0);
        rdc(`ADDR_PCR, 32'h0);
        chk(pc, 16'h0000);
        rdc(`ADDR_VEC, 32'h0);
        rdc(`ADDR_CNT, 32'h0);
        rdc(`ADDR_FLAGS, 32'h0, `FLG_DEF_MASK);
        rdc(8'hFC, 32'h0);
        $display("test reset done");
        wr(`ADDR_VEC, 32'h3C);
        #1;
        chk(vbase, 8'h3C);
        wr(`ADDR_CNT, 32'hFE);
        wr(`ADDR_PCR, 32'hFFFE);
        @(posedge clk);
        fetch <= 1'b1;
        repeat (3) @(posedge clk);
        fetch <= 1'b0;
        #1;
        chk(pc, 16'h0001);
        rdc(`ADDR_CNT, 32'h81);
        $display("test fetch done");
        wr(`ADDR_ACC, 32'h5A);
        xp();
        rdc(`ADDR_ACC, 32'h0);
        wr(`ADDR_ACC, 32'hA5);
        xp();
        rdc(`ADDR_ACC, 32'h5A);
        $display("test exchange done");
        wr(`ADDR_BC, 32'h1122);
        wr(`ADDR_DE, 32'h3344);
        wr(`ADDR_HL, 32'h5566);
        wr(`ADDR_IXR, 32'h7788);
        wr(`ADDR_IYR, 32'h99AA);
        wr(`ADDR_SPR, 32'hBBCC);
        wr(`ADDR_FLAGS, 32'h28);
        m_flags = 8'h28;
        #1;
        chk(sp, 16'hBBCC);
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            bsel <= s[2:0];
            @(posedge clk);
            #1;
            chk(bvalid, s != 6);
            if (s != 6) chk(bop, bt[s]);
        end
        for (int f = 0; f < 4; f++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                pf <= pair_field_t'(f);
                psel <= s[1:0];
                @(posedge clk);
                #1;
                chk(pop, pe(f, s));
            end
        end
        $display("test select done");
        amc(AM_REG_INDIRECT, FT_WW, 2'h0, 2'h0, 8'h00, 16'h1122);
        amc(AM_REG_INDIRECT, FT_WW, 2'h1, 2'h0, 8'h00, 16'h3344);
        amc(AM_REG_INDIRECT, FT_WW, 2'h2, 2'h0, 8'h00, 16'h5566);
        amc(AM_INDEXED, FT_XX, 2'h0, 2'h0, 8'h80, 16'h7708);
        amc(AM_INDEXED, FT_XX, 2'h0, 2'h0, 8'h7F, 16'h7807);
        amc(AM_INDEXED, FT_YY, 2'h0, 2'h0, 8'hFF, 16'h99A9);
        amc(AM_IMPLIED, FT_WW, 2'h0, 2'h1, 8'h00, 16'h7788);
        amc(AM_IMPLIED, FT_WW, 2'h0, 2'h2, 8'h00, 16'hBBCC);
        amc(AM_IMPLIED, FT_WW, 2'h0, 2'h3, 8'h00, 16'h5566);
        amc(AM_IO, FT_WW, 2'h0, 2'h0, 8'h00, 16'h0022);
        lf = nxt(lf);
        @(posedge clk);
        imm <= lf;
        amc(AM_EXTENDED, FT_WW, 2'h0, 2'h0, 8'h00, lf);
        $display("test address done");
        alu(OP_ADD, 8'h7F, 8'h01, 1'b0);
        alu(OP_SUB, 8'h80, 8'h01, 1'b0);
        alu(OP_ADD, 8'hFF, 8'h01, 1'b0);
        alu(OP_SUB, 8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 40; i++) begin
            lf = nxt(lf);
            alu(op_class_t'(i % 4), lf[7:0], lf[15:8], lf[3]);
        end
        alu(OP_SUB, 8'h10, 8'h01, 1'b0);
        rdc(`ADDR_FLAGS, {24'h0, m_flags});
        $display("test flags done");
        stop_test();
    end
endmodule : cpu_register_file_and_flags_test
`default_nettype wire
